// [core/sdi_consts.svh]
// Constants of the serial DAC input interface
`ifndef SDI_CONSTS_SVH
`define SDI_CONSTS_SVH
`define SDI_WORD_BITS 16
`define SDI_BYTE_BITS 8
`define SDI_OVERSAMPLE 16
`define SDI_OVS_MID 7
`define SDI_WORD_RESET 16'h0000
`define SDI_CNT_RESET 5'h00
`endif

// [core/sdi_core.sv]
// Serial input shift register, latch and asynchronous framer of the DAC
`timescale 1ns/1ps
`include "sdi_consts.svh"
// How it works
// R1 - A high latch pin sampled at reset release selects asynchronous mode.
// R2 - In asynchronous mode each bit takes sixteen serial clocks and is sampled mid-bit.
// R3 - The host keeps the asynchronous rate at or below 150 kbit/s, a 2.4 MHz clock; the testbench clocks sclk at 15.625 MHz, about 977 kbit/s.
// R4 - In three-wire mode the host drops the latch pin before the first byte.
// R5 - The code arrives as upper byte then lower byte and forms one 16-bit word.
// R6 - One data bit is captured on each rising serial clock edge.
// R7 - A rising latch edge moves the shifted word into the DAC latch.
// R8 - Bits come most significant first, the first ending as bit 15.
// R9 - In asynchronous mode a start bit, 16 data bits and a stop bit make a frame that loads the word.
// R10 - The last bit of the shift register leaves on the serial output for chaining.
// R11 - The host keeps the serial clock still while the latch is updating.
module sdi_core (
	// System clock
	input wire logic clk,
	input wire logic srst,
	// Serial link
	input wire logic sclk,
	input wire logic sdata_in,
	input wire logic latch_in,
	output logic sdata_out,
	// DAC side
	output sdi_pkg::sdi_code_t dac_code,
	output logic dac_load,
	output logic async_mode
);
	// ----------------------------------------
	// Link domain reset and mode
	// ----------------------------------------
	// Reset crosses into the serial clock domain; sclk is expected running.
	logic lrst_m_q, lrst_q;
	always_ff @(posedge sclk) begin
		lrst_m_q <= srst;
		lrst_q <= lrst_m_q;
	end
	logic latch_m_q, latch_s_q, latch_d1_q;
	always_ff @(posedge sclk) begin
		latch_m_q <= latch_in;
		latch_s_q <= latch_m_q;
		latch_d1_q <= latch_s_q;
	end
	logic amode_q, mode_taken_q;
	always_ff @(posedge sclk) begin
		if (lrst_q) begin
			amode_q <= 1'b0;
			mode_taken_q <= 1'b0;
		end else if (!mode_taken_q) begin
			amode_q <= latch_s_q; // R1
			mode_taken_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Three-wire and asynchronous shift register
	// ----------------------------------------
	// In three-wire mode data is taken directly on the rising sclk; asynchronous data first passes two flops
	sdi_pkg::sdi_word_t shift_q;
	logic [4:0] ovs_q, bit_cnt_q;
	sdi_pkg::sdi_async_st_t st_q;
	logic mid_bit;
	logic data_s_m_q, data_s_q;
	always_ff @(posedge sclk) begin
		data_s_m_q <= sdata_in;
		data_s_q <= data_s_m_q;
	end
	assign mid_bit = (ovs_q == 5'(`SDI_OVS_MID));
	always_ff @(posedge sclk) begin
		if (lrst_q) begin
			shift_q <= `SDI_WORD_RESET;
		end else if (!amode_q) begin
			// Latch moves with the host clock like the data, so it is read directly;
			// while it is high the word stays put even if the clock keeps running
			if (!latch_in) begin // R7
				shift_q <= {shift_q[14:0], sdata_in}; // R6 R8 R5
			end
		end else if (st_q == sdi_pkg::SDI_DATA && mid_bit) begin
			shift_q <= {shift_q[14:0], data_s_q}; // R2 R8
		end
	end
	always_ff @(posedge sclk) begin
		if (lrst_q) begin
			sdata_out <= 1'b0;
		end else begin
			sdata_out <= shift_q[15]; // R10
		end
	end
	// ----------------------------------------
	// Asynchronous framer
	// ----------------------------------------
	logic frame_done_q;
	always_ff @(posedge sclk) begin
		if (lrst_q || !amode_q) begin
			st_q <= sdi_pkg::SDI_IDLE;
			ovs_q <= `SDI_CNT_RESET;
			bit_cnt_q <= `SDI_CNT_RESET;
			frame_done_q <= 1'b0;
		end else begin
			frame_done_q <= 1'b0;
			case (st_q)
				sdi_pkg::SDI_IDLE: begin
					ovs_q <= `SDI_CNT_RESET;
					if (!data_s_q) begin
						st_q <= sdi_pkg::SDI_START; // R9
					end
				end
				sdi_pkg::SDI_START: begin
					if (mid_bit && data_s_q) begin
						// Glitch, not a start bit
						st_q <= sdi_pkg::SDI_IDLE;
					end else if (ovs_q == 5'(`SDI_OVERSAMPLE - 1)) begin
						ovs_q <= `SDI_CNT_RESET;
						bit_cnt_q <= `SDI_CNT_RESET;
						st_q <= sdi_pkg::SDI_DATA;
					end else begin
						ovs_q <= ovs_q + 5'h01;
					end
				end
				sdi_pkg::SDI_DATA: begin
					if (ovs_q == 5'(`SDI_OVERSAMPLE - 1)) begin // R2
						ovs_q <= `SDI_CNT_RESET;
						bit_cnt_q <= bit_cnt_q + 5'h01;
						if (bit_cnt_q == 5'(`SDI_WORD_BITS - 1)) begin
							st_q <= sdi_pkg::SDI_STOP;
						end
					end else begin
						ovs_q <= ovs_q + 5'h01;
					end
				end
				sdi_pkg::SDI_STOP: begin
					if (mid_bit) begin
						// Framing error drops the word
						frame_done_q <= data_s_q; // R9
						st_q <= sdi_pkg::SDI_IDLE;
					end else begin
						ovs_q <= ovs_q + 5'h01;
					end
				end
				default: begin
					st_q <= sdi_pkg::SDI_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// Word latch in link domain
	// ----------------------------------------
	logic load_ev;
	sdi_pkg::sdi_word_t word_q;
	logic load_tgl_q;
	// Latch rise is seen two link clocks late; limitation: the link clock must run again after it
	assign load_ev = amode_q ? frame_done_q : (latch_s_q && !latch_d1_q && mode_taken_q);
	always_ff @(posedge sclk) begin
		if (lrst_q) begin
			word_q <= `SDI_WORD_RESET;
			load_tgl_q <= 1'b0;
		end else if (load_ev) begin
			word_q <= shift_q; // R7 R9
			load_tgl_q <= ~load_tgl_q;
		end
	end
	// ----------------------------------------
	// Crossing to the system clock
	// ----------------------------------------
	logic tgl_s, tgl_d_q, amode_s;
	sdi_sync u_tgl_sync (
		.clk(clk),
		.srst(srst),
		.din(load_tgl_q),
		.dout(tgl_s)
	);
	sdi_sync u_mode_sync (
		.clk(clk),
		.srst(srst),
		.din(amode_q),
		.dout(amode_s)
	);
	// Word is stable for many clk cycles after the toggle, so it is sampled directly
	always_ff @(posedge clk) begin
		if (srst) begin
			tgl_d_q <= 1'b0;
			dac_load <= 1'b0;
			dac_code <= `SDI_WORD_RESET;
			async_mode <= 1'b0;
		end else begin
			tgl_d_q <= tgl_s;
			dac_load <= tgl_s ^ tgl_d_q;
			async_mode <= amode_s;
			if (tgl_s ^ tgl_d_q) begin
				dac_code <= word_q; // R7
			end
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Past reset in the antecedents keeps the unknown start-up edges vacuous
	chk_out_chain: assert property (@(posedge sclk) disable iff (lrst_q) // R10
		!$past(lrst_q) |-> sdata_out == $past(shift_q[15])) else $error("serial out not last bit");
	chk_three_shift: assert property (@(posedge sclk) disable iff (lrst_q) // R6
		!$past(lrst_q) && !$past(amode_q) && !$past(latch_in) |-> shift_q[0] == $past(sdata_in))
		else $error("bit not shifted");
	chk_msb_order: assert property (@(posedge sclk) disable iff (lrst_q) // R8
		!$past(lrst_q) && !$past(amode_q) && !$past(latch_in) |-> shift_q[15:1] == $past(shift_q[14:0]))
		else $error("wrong bit order");
	chk_shift_hold: assert property (@(posedge sclk) disable iff (lrst_q) // R7
		!$past(lrst_q) && !$past(amode_q) && $past(latch_in) |-> $stable(shift_q))
		else $error("word moved under latch");
	chk_latch_word: assert property (@(posedge sclk) disable iff (lrst_q) // R7
		load_ev |=> word_q == $past(shift_q)) else $error("word not latched");
	chk_dac_load: assert property (@(posedge sclk) disable iff (lrst_q) // R7
		load_ev |=> load_tgl_q != $past(load_tgl_q)) else $error("load event lost");
	chk_ovs_bound: assert property (@(posedge sclk) disable iff (lrst_q) // R2
		!lrst_q |-> ovs_q < 5'(`SDI_OVERSAMPLE)) else $error("oversample count overrun");
	chk_frame_stop: assert property (@(posedge sclk) disable iff (lrst_q) // R9
		frame_done_q |-> $past(st_q) == sdi_pkg::SDI_STOP && $past(data_s_q)) else $error("frame without stop");
	chk_mode_hold: assert property (@(posedge sclk) disable iff (lrst_q) // R1
		$past(mode_taken_q) |-> $stable(amode_q)) else $error("mode changed");
	chk_async_byte: assert property (@(posedge sclk) disable iff (lrst_q) // R2
		(st_q == sdi_pkg::SDI_DATA && mid_bit) |=> shift_q[0] == $past(data_s_q)) else $error("async bit");
	cov_three_load: cover property (@(posedge sclk) !amode_q && load_ev);
	cov_async_frame: cover property (@(posedge sclk) amode_q && frame_done_q);
	cov_frame_drop: cover property (@(posedge sclk) st_q == sdi_pkg::SDI_STOP && mid_bit && !data_s_q);
	cov_dac_update: cover property (@(posedge clk) dac_load);
endmodule : sdi_core

// [core/sdi_pkg.sv]
// Types of the serial DAC input interface
package sdi_pkg;
	typedef logic [15:0] sdi_word_t;
	typedef struct packed {
		logic [7:0] upper_byte;
		logic [7:0] lower_byte;
	} sdi_code_t;
	typedef enum logic [3:0] {
		SDI_IDLE = 4'h1,
		SDI_START = 4'h2,
		SDI_DATA = 4'h4,
		SDI_STOP = 4'h8
	} sdi_async_st_t;
endpackage : sdi_pkg

// [core/sdi_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
module sdi_sync (
	// Clock
	input wire logic clk,
	input wire logic srst,
	// Level
	input wire logic din,
	output logic dout
);
	logic meta_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : sdi_sync

// [dv/sdi_host.sv]
// Host serial port model for the DAC link
`timescale 1ns/1ps
module sdi_host (
	// Link
	input wire logic sclk,
	output logic sdata_in,
	output logic latch_in,
	output logic sclk_hold
);
	// sclk is the free-running source; the link sees it gated by sclk_hold
	initial begin
		sdata_in = 1'b1;
		latch_in = 1'b0;
		sclk_hold = 1'b0;
	end
	task automatic strap(input logic v);
		@(negedge sclk);
		latch_in = v;
	endtask : strap
	// Changes on falling edges so data is settled at each rise
	task automatic send3(input logic [15:0] w);
		@(negedge sclk);
		latch_in = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(negedge sclk);
			sdata_in = w[i];
		end
		@(negedge sclk);
		sdata_in = ~w[0];
		latch_in = 1'b1;
		// Clock stays low while the DAC latch updates, then runs on so the latch is seen
		sclk_hold = 1'b1;
		repeat (4) @(negedge sclk);
		sclk_hold = 1'b0;
	endtask : send3
	task automatic send_async(input logic [15:0] w, input logic stop);
		logic [17:0] f;
		f = {1'b0, w, stop};
		for (int i = 17; i >= 0; i--) begin
			@(negedge sclk);
			sdata_in = f[i];
			repeat (15) @(negedge sclk);
		end
		@(negedge sclk);
		sdata_in = 1'b1;
	endtask : send_async
endmodule : sdi_host

// [dv/test_sdi_core.sv]
// Testbench of the serial DAC input core
`timescale 1ns/1ps
module test_sdi_core;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sclk_free = 1'b0;
	logic sclk_hold;
	logic sclk;
	logic sdata_in;
	logic latch_in;
	logic sdata_out;
	logic dac_load;
	logic async_mode;
	sdi_pkg::sdi_code_t dac_code;
	int err_total = 0;
	int checks = 0;
	always #5 clk = ~clk;
	// Half period of 32 ns meets a clk edge every 160 ns; the host gates it while latching
	always #32 sclk_free = ~sclk_free;
	assign sclk = sclk_free & ~sclk_hold;
	sdi_core dut (.clk(clk), .srst(srst), .sclk(sclk), .sdata_in(sdata_in), .latch_in(latch_in),
		.sdata_out(sdata_out), .dac_code(dac_code), .dac_load(dac_load), .async_mode(async_mode));
	sdi_host host (.sclk(sclk_free), .sdata_in(sdata_in), .latch_in(latch_in), .sclk_hold(sclk_hold));
	task automatic test_done;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task automatic cmp_code(input sdi_pkg::sdi_code_t exp);
		checks++;
		if (dac_code !== exp) begin
			err_total++;
			$display("wrong value at %0t: code %h expected %h", $time, dac_code, exp);
		end
	endtask : cmp_code
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit
	// Fixed window long enough for a whole asynchronous frame
	task automatic wait_load(input logic want);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 2500; i++) begin
			@(negedge clk);
			if (dac_load === 1'b1) seen = 1'b1;
		end
		cmp_bit(seen, want);
		if (want && !seen) test_done;
	endtask : wait_load
	// Link reset needs several link clock edges, not only 3 clk
	task automatic do_reset(input logic s);
		host.strap(s);
		@(negedge clk);
		srst = 1'b1;
		repeat (3) @(negedge clk);
		repeat (4) @(posedge sclk);
		@(negedge clk);
		srst = 1'b0;
		repeat (8) @(posedge sclk);
	endtask : do_reset
	task automatic t_three;
		logic [15:0] w[2] = '{16'h8001, 16'h7FFE};
		do_reset(1'b0);
		cmp_bit(async_mode, 1'b0);
		foreach (w[k]) begin
			fork
				host.send3(w[k]);
				wait_load(1'b1);
			join
			cmp_code(w[k]);
			cmp_bit(sdata_out, w[k][15]);
		end
		$display("three_wire done");
	endtask : t_three
	task automatic t_async;
		do_reset(1'b1);
		cmp_bit(async_mode, 1'b1);
		fork
			host.send_async(16'h3C5A, 1'b1);
			wait_load(1'b1);
		join
		cmp_code(16'h3C5A);
		fork
			host.send_async(16'hC3A5, 1'b0);
			wait_load(1'b0);
		join
		cmp_code(16'h3C5A);
		cmp_bit(sdata_out, 1'b1);
		$display("async done");
	endtask : t_async
	initial begin
		t_three();
		t_async();
		test_done();
	end
endmodule : test_sdi_core
